// ### core/ext_bus_cs3_cfg.sv
// chip-select-3 window, bus mode selection and strobe timing with apb registers
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "ext_bus_cs3_regs.svh"

module ext_bus_cs3_cfg
    import ext_bus_cs3_pkg::*;
(
    // clock and power-on reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // other resets
    input  wire logic                  pciRstPin,
    input  wire logic                  softRst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // host i/o cycle
    input  wire logic                  ioStart,
    input  wire logic                  ioWrite,
    input  wire logic [15:0]           ioAddr,
    output logic                       syncWait,
    output logic                       ioDone,
    // expansion bus
    output logic                       ext_select_three_n,
    output logic                       readStrobeN,
    output logic                       writeStrobeN
);
    // registers
    logic [7:0]        cs3High;
    logic [7:0]        cs3Low;
    logic [7:0]        busSel;
    logic              lastHit;
    cycle_state_type   state;
    cycle_state_type   next_state;

    // register load values
    logic [7:0]        lowWriteValue;
    logic [7:0]        lowSoftValue;
    logic [7:0]        busWriteValue;
    logic [7:0]        busSoftValue;

    // reset and decode wires
    logic              pciRst;
    logic              cfgClear;
    logic [`IDX_W-1:0] wordIdx;
    logic              selHigh;
    logic              selLow;
    logic              selBus;
    logic              selStatus;
    logic              mapped;
    logic              setupRead;
    logic              accessWrite;
    logic              baseLocked;
    logic              selLocked;
    logic [7:0]        readMux;
    logic [7:0]        statusWord;

    // window wires
    bus_mode_type      mode;
    logic [15:0]       baseAddr;
    logic              highBitsZero;
    logic              windowValid;
    logic              addrMatch;
    logic              hit;
    logic              takeCycle;

    // strobe width wires
    logic [1:0]        widthCode;
    logic [`CNT_W-1:0] widthCycles;
    logic              timerBusy;
    logic              timerExpired;

    // pci reset arrives from a pin
    bit_sync2 pciSync
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn (pciRstPin),
        .syncOut (pciRst)
    );

    // soft reset returns values to defaults but leaves the locks alone
    assign cfgClear = softRst & ~pciRst;

    // apb decode
    assign wordIdx     = paddr[`APB_ADDR_W-1:2];
    assign selHigh     = (wordIdx == `IDX_CS3_HIGH);
    assign selLow      = (wordIdx == `IDX_CS3_LOW);
    assign selBus      = (wordIdx == `IDX_BUS_SEL);
    assign selStatus   = (wordIdx == `IDX_STATUS);
    assign mapped      = selHigh | selLow | selBus | selStatus;
    assign setupRead   = psel & ~penable & ~pwrite;
    assign accessWrite = psel & penable & pwrite & mapped;
    // zero wait states, every access phase completes at once
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~mapped;

    // lock states
    assign baseLocked = cs3Low[`CS3_LOCK_BIT];
    assign selLocked  = busSel[`SEL_LOCK_BIT];

    // load values; soft reset keeps the lock bits
    assign lowWriteValue = {pwdata[7:2], pwdata[`CS3_LOCK_BIT], pwdata[`CS3_DISABLE_BIT]};
    assign lowSoftValue  = {6'(`RST_CS3_LOW >> 2), baseLocked, 1'(`RST_CS3_LOW)};
    assign busWriteValue = pwdata[7:0] & `SEL_STORE_MASK;
    assign busSoftValue  = `RST_BUS_SEL | {selLocked, 7'h00};

    // status word
    assign statusWord = {4'h0,
                         lastHit,
                         mode == MODE_TWO,
                         windowValid,
                         state != ST_IDLE};

    // read selection, reserved bits read zero
    assign readMux = selHigh   ? cs3High :
                     selLow    ? cs3Low :
                     selBus    ? (busSel & `SEL_STORE_MASK) :
                     selStatus ? statusWord :
                     8'h00;

    // read data captured in the setup phase
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (setupRead)
            prdata <= {24'h00_0000, readMux};
    end

    // chip-select-3 high byte, address 15:8
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cs3High <= `RST_CS3_HIGH;
        else if (pciRst || cfgClear)
            cs3High <= `RST_CS3_HIGH;
        else if (accessWrite && selHigh && !baseLocked)
            cs3High <= pwdata[7:0];
    end

    // chip-select-3 low byte; the lock can be set by software but not cleared
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cs3Low <= `RST_CS3_LOW;
        else if (pciRst)
            cs3Low <= `RST_CS3_LOW;
        else if (cfgClear)
            cs3Low <= lowSoftValue;
        else if (accessWrite && selLow && !baseLocked)
            cs3Low <= lowWriteValue;
    end

    // bus selection register; lock holds through writes and soft reset
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            busSel <= `RST_BUS_SEL;
        else if (pciRst)
            busSel <= `RST_BUS_SEL;
        else if (cfgClear)
            busSel <= busSoftValue;
        else if (accessWrite && selBus && !selLocked)
            busSel <= busWriteValue;
    end

    // mode choice only steers decoding; pin functions stay as software set them
    assign mode = bus_mode_type'(busSel[`SEL_MODE_BIT]);

    // base address as seen by the decoder in the current mode
    assign baseAddr = (mode == MODE_ONE) ?
                      {cs3High, cs3Low[7:2], 2'b00} :
                      {cs3High, cs3Low[7:4], 4'h0};

    // window qualification over 16 address bits
    assign highBitsZero = (cs3High[7:4] == 4'h0);
    assign windowValid  = highBitsZero &&
                          (baseAddr >= `WIN_RANGE_LO) &&
                          (baseAddr <= `WIN_RANGE_HI);

    // address compare per mode
    assign addrMatch = (mode == MODE_ONE) ?
                       (ioAddr[15:2] == baseAddr[15:2]) :
                       (ioAddr[15:4] == baseAddr[15:4]);

    // disabled or invalid windows never select
    assign hit       = addrMatch && windowValid &&
                       !cs3Low[`CS3_DISABLE_BIT];
    // a start while a cycle runs is dropped
    assign takeCycle = ioStart && hit && (state == ST_IDLE);

    // strobe width selection, least times rounded up to whole cycles
    assign widthCode   = busSel[`SEL_WIDTH_MSB:`SEL_WIDTH_LSB];
    assign widthCycles = (widthCode == 2'b11) ? `CNT_W'(`STROBE_CYC(`STROBE_NS_3)) :
                         (widthCode == 2'b10) ? `CNT_W'(`STROBE_CYC(`STROBE_NS_2)) :
                         (widthCode == 2'b01) ? `CNT_W'(`STROBE_CYC(`STROBE_NS_1)) :
                         `CNT_W'(`STROBE_CYC(`STROBE_NS_0));

    // timer loaded on the accepted start
    strobe_timer widthTimer
    (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .start     (takeCycle),
        .loadCount (widthCycles),
        .busy      (timerBusy),
        .expired   (timerExpired)
    );

    // cycle sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (takeCycle)
                    next_state = ST_STROBE;
            end
            ST_STROBE:
            begin
                if (timerExpired)
                    next_state = ST_DONE;
            end
            ST_DONE:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // last decode result, kept for the status word
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lastHit <= 1'b0;
        end
        else if (ioStart && (state == ST_IDLE))
        begin
            lastHit <= hit;
        end
    end

    // wait syncs while the strobe runs, completion once it has
    assign syncWait = (state == ST_STROBE) && timerBusy;
    assign ioDone   = (state == ST_DONE);

    // select and strobes, driven from flip-flops
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ext_select_three_n <= 1'b1;
            readStrobeN        <= 1'b1;
            writeStrobeN       <= 1'b1;
        end
        else if (takeCycle)
        begin
            ext_select_three_n <= 1'b0;
            readStrobeN        <= ioWrite;
            writeStrobeN       <= ~ioWrite;
        end
        else if (timerExpired)
        begin
            ext_select_three_n <= 1'b1;
            readStrobeN        <= 1'b1;
            writeStrobeN       <= 1'b1;
        end
    end
endmodule

// ### core/ext_bus_cs3_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef EXT_BUS_CS3_REGS_SVH
`define EXT_BUS_CS3_REGS_SVH

// apb address width; byte address is four times the register index
`define APB_ADDR_W        10
`define IDX_W             8

// register indices
`define IDX_CS3_HIGH      8'h66
`define IDX_CS3_LOW       8'h67
`define IDX_STATUS        8'h6f
`define IDX_BUS_SEL       8'hf0

// reset values
`define RST_CS3_HIGH      8'h00
`define RST_CS3_LOW       8'h00
`define RST_BUS_SEL       8'h0c

// chip-select-3 low byte fields
`define CS3_DISABLE_BIT   0
`define CS3_LOCK_BIT      1

// bus selection fields
`define SEL_MODE_BIT      0
`define SEL_WIDTH_LSB     2
`define SEL_WIDTH_MSB     3
`define SEL_LOCK_BIT      7
`define SEL_STORE_MASK    8'h8d

// status fields
`define STAT_BUSY_BIT     0
`define STAT_VALID_BIT    1
`define STAT_MODE_BIT     2
`define STAT_HIT_BIT      3

// permitted window range for this logical device
`define WIN_RANGE_LO      16'h0100
`define WIN_RANGE_HI      16'h0ffc

// strobe timing
`define CLK_PERIOD_NS     8
`define STROBE_NS_0       180
`define STROBE_NS_1       300
`define STROBE_NS_2       420
`define STROBE_NS_3       540
`define STROBE_CYC(ns)    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W             7

`endif

// ### core/ext_bus_cs3_pkg.sv
// types shared by the expansion bus configuration block
package ext_bus_cs3_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_STROBE = 2'b01,
        ST_DONE   = 2'b11
    } cycle_state_type;

    typedef enum logic
    {
        MODE_ONE = 1'b0,
        MODE_TWO = 1'b1
    } bus_mode_type;

endpackage

// ### core/bit_sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module bit_sync2
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // level
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic firstStage;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            firstStage <= 1'b0;
            syncOut    <= 1'b0;
        end
        else
        begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end
endmodule

// ### core/strobe_timer.sv
// down counter holding busy for exactly the loaded number of cycles
`timescale 1ns/1ns
`include "ext_bus_cs3_regs.svh"
module strobe_timer
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // control
    input  wire logic              start,
    input  wire logic [`CNT_W-1:0] loadCount,
    // status
    output logic                   busy,
    output logic                   expired
);
    logic [`CNT_W-1:0] count;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            count <= '0;
        else if (start)
            count <= loadCount;
        else if (count != '0)
            count <= count - 1'b1;
    end

    assign busy    = (count != '0);
    assign expired = (count == `CNT_W'(1));
endmodule

// ### dv/ext_bus_cs3_cfg_chk.sv
// checker for select three timing at the ports of the configuration block
`timescale 1ns/1ns
module ext_bus_cs3_cfg_chk
(
    // clock and resets
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pciRstPin,
    // host cycle and expansion bus
    input wire logic ioStart,
    input wire logic syncWait,
    input wire logic ioDone,
    input wire logic ext_select_three_n,
    input wire logic readStrobeN,
    input wire logic writeStrobeN
);
    logic [7:0] lowCnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst || pciRstPin);
    // cycles the select has been low so far
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
            lowCnt <= 8'h00;
        else
            lowCnt <= ext_select_three_n ? 8'h00 : lowCnt + 8'h01;
    sel_start_a: assert property ($fell(ext_select_three_n) |-> $past(ioStart))
        else $error("select fell without a host cycle start");
    sel_min_a: assert property ($fell(ext_select_three_n) |-> (!ext_select_three_n) [*8])
        else $error("select pulse too short");
    sel_max_a: assert property (lowCnt <= 8'h44)
        else $error("select pulse too long");
    width_code_a: assert property ($rose(ext_select_three_n) |->
        lowCnt inside {8'h17, 8'h26, 8'h35, 8'h44})
        else $error("select pulse length is not a strobe width");
    done_after_a: assert property ($rose(ext_select_three_n) |-> ioDone)
        else $error("no completion after the strobe");
    done_only_a: assert property (ioDone |-> !$past(ext_select_three_n))
        else $error("completion without a strobe");
    wait_cover_a: assert property (syncWait == !ext_select_three_n)
        else $error("wait syncs do not match the strobe");
    strobe_pair_a: assert property (!ext_select_three_n |-> (readStrobeN ^ writeStrobeN))
        else $error("not exactly one strobe during select");
    cover property ($rose(ext_select_three_n) && lowCnt == 8'h17);
    cover property ($rose(ext_select_three_n) && lowCnt == 8'h44);
    cover property ($fell(ext_select_three_n) && !writeStrobeN);
endmodule

bind ext_bus_cs3_cfg ext_bus_cs3_cfg_chk i_chk
(
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .pciRstPin          (pciRstPin),
    .ioStart            (ioStart),
    .syncWait           (syncWait),
    .ioDone             (ioDone),
    .ext_select_three_n (ext_select_three_n),
    .readStrobeN        (readStrobeN),
    .writeStrobeN       (writeStrobeN)
);

// ### dv/ext_periph_model.sv
// expansion bus peripheral that measures select pulses and records whether the write strobe was active
`timescale 1ns/1ns
module ext_periph_model
(
    // clock
    input wire logic ref_clk,
    // expansion bus
    input wire logic ext_select_three_n,
    input wire logic writeStrobeN,
    // observations
    output int       pulseCount,
    output int       lastWidth,
    output logic     lastWrite
);
    int run;
    initial
    begin
        run = 0;
        pulseCount = 0;
        lastWidth = 0;
        lastWrite = 1'b0;
    end
    always @(posedge ref_clk)
        if (!ext_select_three_n)
        begin
            run <= run + 1;
            lastWrite <= !writeStrobeN;
        end
        else if (run != 0)
        begin
            lastWidth <= run;
            pulseCount <= pulseCount + 1;
            run <= 0;
        end
endmodule

// ### dv/test_ext_bus_cs3_cfg.sv
// self-checking bench for the expansion bus configuration block
`timescale 1ns/1ns
`include "ext_bus_cs3_regs.svh"
module test_ext_bus_cs3_cfg import ext_bus_cs3_pkg::*;;
    logic ref_clk = 1'b0, sys_rst = 1'b1, pciRstPin = 1'b0, softRst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ioStart = 1'b0, ioWrite = 1'b0;
    logic [`APB_ADDR_W-1:0] paddr = '0;
    logic [31:0]            pwdata = '0, prdata, rv;
    logic [15:0]            ioAddr = '0;
    logic                   pready, pslverr, er, syncWait, ioDone, selN, rdN, wrN, lastWr;
    int                     n_mismatch = 0, cmp_count = 0, pulses, width;
    int                     ns[4] = '{180, 300, 420, 540};

    ext_bus_cs3_cfg i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .pciRstPin(pciRstPin),
        .softRst(softRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ioStart(ioStart), .ioWrite(ioWrite), .ioAddr(ioAddr), .syncWait(syncWait),
        .ioDone(ioDone), .ext_select_three_n(selN), .readStrobeN(rdN), .writeStrobeN(wrN));
    ext_periph_model i_periph (.ref_clk(ref_clk), .ext_select_three_n(selN),
        .writeStrobeN(wrN), .pulseCount(pulses), .lastWidth(width), .lastWrite(lastWr));

    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            wrap_up();
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rv, exp);
    endtask

    // n is the expected strobe length in cycles, 0 when no select may follow
    task automatic host(input logic [15:0] a, input logic w, input int n);
        int p;
        int seen;
        int waits;
        p = pulses;
        seen = 0;
        waits = 0;
        ioStart <= 1'b1;
        ioWrite <= w;
        ioAddr <= a;
        @(posedge ref_clk);
        ioStart <= 1'b0;
        for (int k = 0; k < 80; k++)
        begin
            @(negedge ref_clk);
            if (ioDone === 1'b1)
                seen++;
            if (syncWait === 1'b1)
                waits++;
            @(posedge ref_clk);
        end
        check(seen, n != 0);
        check(waits, n);
        check(pulses - p, n != 0);
        if (n != 0)
        begin
            check(width, n);
            check(lastWr, w);
        end
    endtask

    task automatic t_reset();
        rdchk(`IDX_CS3_LOW, 32'h00);
        rdchk(`IDX_BUS_SEL, 32'h0c);
        apb(1'b0, 8'h70, 8'h00);
        check(er, 1'b1);
    endtask

    task automatic t_decode();
        apb(1'b1, `IDX_CS3_HIGH, 8'h01);
        apb(1'b1, `IDX_CS3_LOW, 8'h20);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, `IDX_BUS_SEL, 8'(c << 2));
            rdchk(`IDX_BUS_SEL, c << 2);
            host(16'h0120, c[0], (ns[c] + 7) / 8);
        end
        host(16'h0124, 1'b0, 0);
        apb(1'b1, `IDX_CS3_LOW, 8'h2c);
        host(16'h0120, 1'b0, 0);
        apb(1'b1, `IDX_BUS_SEL, 8'h01);
        rdchk(`IDX_CS3_LOW, 32'h2c);
        host(16'h0120, 1'b1, 23);
        rdchk(`IDX_STATUS, 32'h0e);
        host(16'h0130, 1'b0, 0);
        rdchk(`IDX_STATUS, 32'h06);
        apb(1'b1, `IDX_CS3_LOW, 8'h21);
        host(16'h0120, 1'b0, 0);
        apb(1'b1, `IDX_CS3_LOW, 8'h20);
        apb(1'b1, `IDX_CS3_HIGH, 8'h00);
        host(16'h0020, 1'b0, 0);
        apb(1'b1, `IDX_CS3_HIGH, 8'h11);
        host(16'h1120, 1'b0, 0);
    endtask

    task automatic t_lock();
        apb(1'b1, `IDX_CS3_HIGH, 8'h01);
        apb(1'b1, `IDX_CS3_LOW, 8'h22);
        apb(1'b1, `IDX_CS3_LOW, 8'h00);
        apb(1'b1, `IDX_CS3_HIGH, 8'h05);
        rdchk(`IDX_CS3_LOW, 32'h22);
        rdchk(`IDX_CS3_HIGH, 32'h01);
        apb(1'b1, `IDX_BUS_SEL, 8'h8d);
        apb(1'b1, `IDX_BUS_SEL, 8'h00);
        rdchk(`IDX_BUS_SEL, 32'h8d);
        host(16'h012c, 1'b1, 68);
        softRst <= 1'b1;
        @(posedge ref_clk);
        softRst <= 1'b0;
        @(posedge ref_clk);
        rdchk(`IDX_CS3_LOW, 32'h02);
        rdchk(`IDX_BUS_SEL, 32'h8c);
        pciRstPin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pciRstPin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdchk(`IDX_CS3_LOW, 32'h00);
        rdchk(`IDX_BUS_SEL, 32'h0c);
        apb(1'b1, `IDX_CS3_LOW, 8'h24);
        rdchk(`IDX_CS3_LOW, 32'h24);
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_decode();
        t_lock();
        wrap_up();
    end
endmodule
